/* design/io_mode_pkg.sv */
// constants and types shared by the pin mode control block
package io_mode_pkg;

    localparam int DW = 8;
    localparam int AW = 5;
    localparam int PW = 8;

    // register offsets
    localparam logic [AW-1:0] ADDR_P0_SEL_LO = 5'h00;
    localparam logic [AW-1:0] ADDR_P0_SEL_HI = 5'h01;
    localparam logic [AW-1:0] ADDR_P1_SEL_LO = 5'h02;
    localparam logic [AW-1:0] ADDR_P1_SEL_HI = 5'h03;
    localparam logic [AW-1:0] ADDR_P0_DATA   = 5'h04;
    localparam logic [AW-1:0] ADDR_P1_DATA   = 5'h05;
    localparam logic [AW-1:0] ADDR_P0_EDGE   = 5'h06;
    localparam logic [AW-1:0] ADDR_P1_EDGE   = 5'h07;
    localparam logic [AW-1:0] ADDR_P0_PULLUP = 5'h08;
    localparam logic [AW-1:0] ADDR_P1_PULLUP = 5'h09;
    localparam logic [AW-1:0] ADDR_P0_SINK   = 5'h0A;
    localparam logic [AW-1:0] ADDR_P1_SINK   = 5'h0B;
    localparam logic [AW-1:0] ADDR_P0_INPUT  = 5'h0C;
    localparam logic [AW-1:0] ADDR_P1_INPUT  = 5'h0D;
    localparam logic [AW-1:0] ADDR_AUX_IN    = 5'h0E;
    localparam logic [AW-1:0] ADDR_I2C_CTL   = 5'h0F;
    localparam logic [AW-1:0] ADDR_P0_COUNT  = 5'h10;
    localparam logic [AW-1:0] ADDR_P1_COUNT  = 5'h11;
    localparam logic [AW-1:0] ADDR_STATUS    = 5'h12;
    localparam logic [AW-1:0] ADDR_MASK      = 5'h13;

    // field positions
    localparam int CTL_I2C_EN_BIT  = 0;
    localparam int CTL_I2C_RX_BIT  = 1;
    localparam int AUX_CLKPIN_BIT  = 1;
    localparam int ST_P0_EVENT_BIT = 0;
    localparam int ST_P1_EVENT_BIT = 1;
    localparam int ST_CLKPIN_BIT   = 2;
    localparam int SCL_PIN_DEF     = 0;
    localparam int SDA_PIN_DEF     = 1;

    // reset values
    localparam logic [DW-1:0] SEL_LO_RST = 8'h00;
    localparam logic [DW-1:0] SEL_HI_RST = 8'hFF;
    localparam logic [DW-1:0] DATA_RST   = 8'hFF;
    localparam logic [DW-1:0] EDGE_RST   = 8'hFF;
    localparam logic [DW-1:0] ZERO_RST   = 8'h00;
    localparam logic [DW-1:0] ALL_ONES   = 8'hFF;

    // drive modes, {drive_select_high, drive_select_low}
    localparam logic [1:0] MODE_HIZ  = 2'h0;
    localparam logic [1:0] MODE_MED  = 2'h1;
    localparam logic [1:0] MODE_PULL = 2'h2;
    localparam logic [1:0] MODE_HIGH = 2'h3;

    typedef enum logic [1:0] {
        SINK_OFF  = 2'h0,
        SINK_LOW  = 2'h1,
        SINK_MED  = 2'h2,
        SINK_HIGH = 2'h3
    } sink_t;

    typedef struct packed {
        logic  o;
        logic  oe;
        logic  pu;
        sink_t sink;
    } pin_drive_t;

    localparam pin_drive_t DRIVE_RST = '{o: 1'b1, oe: 1'b0, pu: 1'b1, sink: SINK_OFF};

endpackage

/* design/io_sync2.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module io_sync2 #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // ones at reset match the pulled-up idle level, so no false edge
    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta_r <= '1;
            q      <= '1;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule
`default_nettype wire

/* design/io_drive_cell.sv */
// one pin: mode and data level to registered pad drive controls
`timescale 1ns/100ps
`default_nettype none
module io_drive_cell (
    input  wire logic                    clk,
    input  wire logic                    nrst,
    input  wire logic [1:0]              mode,
    input  wire logic                    data,
    output var  io_mode_pkg::pin_drive_t drive_r
);
    io_mode_pkg::pin_drive_t drive_nxt;

    always_comb begin
        drive_nxt = io_mode_pkg::DRIVE_RST;
        case (mode)
            io_mode_pkg::MODE_HIZ: begin
                drive_nxt = '{o: data, oe: 1'b0, pu: 1'b0, sink: io_mode_pkg::SINK_OFF};
            end
            io_mode_pkg::MODE_MED: begin
                drive_nxt = data ? '{o: 1'b1, oe: 1'b1, pu: 1'b0, sink: io_mode_pkg::SINK_OFF}
                                 : '{o: 1'b0, oe: 1'b1, pu: 1'b0, sink: io_mode_pkg::SINK_MED};
            end
            io_mode_pkg::MODE_PULL: begin
                drive_nxt = data ? '{o: 1'b1, oe: 1'b0, pu: 1'b1, sink: io_mode_pkg::SINK_OFF}
                                 : '{o: 1'b0, oe: 1'b1, pu: 1'b0, sink: io_mode_pkg::SINK_LOW};
            end
            io_mode_pkg::MODE_HIGH: begin
                drive_nxt = data ? '{o: 1'b1, oe: 1'b1, pu: 1'b0, sink: io_mode_pkg::SINK_OFF}
                                 : '{o: 1'b0, oe: 1'b1, pu: 1'b0, sink: io_mode_pkg::SINK_HIGH};
            end
            default: begin
                drive_nxt = io_mode_pkg::DRIVE_RST;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            drive_r <= io_mode_pkg::DRIVE_RST;
        end else begin
            drive_r <= drive_nxt;
        end
    end
endmodule
`default_nettype wire

/* design/io_pin_mode_control.sv */
// per-pin drive mode control for two general-purpose io ports
//
// Function
// - each pin keeps its own two mode bits, so changing one pin leaves the others alone.
// - mode 00 is hi-z, 01 medium sink with active high, 10 low sink with pull-up, 11 high sink.
// - after power-up every pin sits in mode 2 and is driven high through the pull-up.
// - the obsolete pull-up and sink-current setups are accepted but change nothing.
// - each of the four mode setups writes its value into the matching mode bits of its port.
// - with i2c active the clock and data pins use mode 1, or mode 2 while receiving.
// - the per-port edge setup picks which input edge the event counter of that port counts.
// - the former clock pin is a plain input read back in bit 1 of the auxiliary input byte.
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module io_pin_mode_control #(
    parameter int W       = io_mode_pkg::PW,
    parameter int SCL_PIN = io_mode_pkg::SCL_PIN_DEF,
    parameter int SDA_PIN = io_mode_pkg::SDA_PIN_DEF
) (
    input  wire logic                            REF_CLK,
    input  wire logic                            NRST,
    input  wire logic [io_mode_pkg::AW-1:0]      ADDR,
    input  wire logic [io_mode_pkg::DW-1:0]      WDATA,
    input  wire logic                            WR,
    input  wire logic                            RD,
    output var  logic [io_mode_pkg::DW-1:0]      RDATA,
    input  wire logic [W-1:0]                    P0_IN,
    input  wire logic [W-1:0]                    P1_IN,
    input  wire logic                            CLK_PIN_IN,
    output var  io_mode_pkg::pin_drive_t [W-1:0] P0_PIN,
    output var  io_mode_pkg::pin_drive_t [W-1:0] P1_PIN,
    output var  logic                            IRQ
);
    // register state, index 0 is port 0
    logic [1:0][W-1:0] sel_lo_r;
    logic [1:0][W-1:0] sel_hi_r;
    logic [1:0][W-1:0] data_r;
    logic [1:0][W-1:0] edge_r;
    logic [1:0][7:0]   count_r;
    logic [7:0]        ctl_r;
    logic [7:0]        status_r;
    logic [7:0]        mask_r;
    logic [7:0]        rdata_r;
    logic              irq_r;

    // synchronised inputs and their previous values
    logic [1:0][W-1:0] pin_s;
    logic [1:0][W-1:0] pin_prev_r;
    logic              clkpin_s;
    logic              clkpin_prev_r;

    // write decode
    wire [1:0] sel_lo_we;
    wire [1:0] sel_hi_we;
    wire [1:0] data_we;
    wire [1:0] edge_we;
    wire [1:0] count_we;
    wire       ctl_we;
    wire       mask_we;
    wire       status_rd;

    assign sel_lo_we[0] = WR && (ADDR == io_mode_pkg::ADDR_P0_SEL_LO);
    assign sel_hi_we[0] = WR && (ADDR == io_mode_pkg::ADDR_P0_SEL_HI);
    assign sel_lo_we[1] = WR && (ADDR == io_mode_pkg::ADDR_P1_SEL_LO);
    assign sel_hi_we[1] = WR && (ADDR == io_mode_pkg::ADDR_P1_SEL_HI);
    assign data_we[0]   = WR && (ADDR == io_mode_pkg::ADDR_P0_DATA);
    assign data_we[1]   = WR && (ADDR == io_mode_pkg::ADDR_P1_DATA);
    assign edge_we[0]   = WR && (ADDR == io_mode_pkg::ADDR_P0_EDGE);
    assign edge_we[1]   = WR && (ADDR == io_mode_pkg::ADDR_P1_EDGE);
    assign count_we[0]  = WR && (ADDR == io_mode_pkg::ADDR_P0_COUNT);
    assign count_we[1]  = WR && (ADDR == io_mode_pkg::ADDR_P1_COUNT);
    assign ctl_we       = WR && (ADDR == io_mode_pkg::ADDR_I2C_CTL);
    assign mask_we      = WR && (ADDR == io_mode_pkg::ADDR_MASK);
    assign status_rd    = RD && (ADDR == io_mode_pkg::ADDR_STATUS);
    // legacy pull-up and sink setups decode to no write enable at all,
    // so the bus takes them like any store and nothing moves

    // input synchronisers
    io_sync2 #(
        .W (W)
    ) u_sync_p0 (
        .clk  (REF_CLK),
        .nrst (NRST),
        .d    (P0_IN),
        .q    (pin_s[0])
    );

    io_sync2 #(
        .W (W)
    ) u_sync_p1 (
        .clk  (REF_CLK),
        .nrst (NRST),
        .d    (P1_IN),
        .q    (pin_s[1])
    );

    io_sync2 #(
        .W (1)
    ) u_sync_clkpin (
        .clk  (REF_CLK),
        .nrst (NRST),
        .d    (CLK_PIN_IN),
        .q    (clkpin_s)
    );

    // i2c override of the two bus pins on port 0
    wire       i2c_on  = ctl_r[io_mode_pkg::CTL_I2C_EN_BIT];
    wire       i2c_rx  = ctl_r[io_mode_pkg::CTL_I2C_RX_BIT];
    wire [1:0] i2c_mode = i2c_rx ? io_mode_pkg::MODE_PULL : io_mode_pkg::MODE_MED;

    // per-pin mode selection and pad drive
    genvar p;
    genvar i;
    generate
        for (p = 0; p < 2; p++) begin : g_port
            for (i = 0; i < W; i++) begin : g_pin
                wire       is_bus_pin = (p == 0) && ((i == SCL_PIN) || (i == SDA_PIN));
                wire [1:0] own_mode   = {sel_hi_r[p][i], sel_lo_r[p][i]};
                wire [1:0] eff_mode   = (is_bus_pin && i2c_on) ? i2c_mode : own_mode;
                io_mode_pkg::pin_drive_t drive;

                io_drive_cell u_cell (
                    .clk     (REF_CLK),
                    .nrst    (NRST),
                    .mode    (eff_mode),
                    .data    (data_r[p][i]),
                    .drive_r (drive)
                );

                if (p == 0) begin : g_p0
                    assign P0_PIN[i] = drive;
                end else begin : g_p1
                    assign P1_PIN[i] = drive;
                end
            end
        end
    endgenerate

    // edge detection for the event counters
    wire [1:0][W-1:0] rise;
    wire [1:0][W-1:0] fall;
    wire [1:0]        hit;
    wire              clkpin_edge = clkpin_s ^ clkpin_prev_r;

    assign rise[0] = pin_s[0] & ~pin_prev_r[0];
    assign rise[1] = pin_s[1] & ~pin_prev_r[1];
    assign fall[0] = ~pin_s[0] & pin_prev_r[0];
    assign fall[1] = ~pin_s[1] & pin_prev_r[1];
    // a one in the edge register picks the rising edge, a zero the falling
    assign hit[0]  = |((rise[0] & edge_r[0]) | (fall[0] & ~edge_r[0]));
    assign hit[1]  = |((rise[1] & edge_r[1]) | (fall[1] & ~edge_r[1]));

    // sticky event status: a set in the clearing cycle survives
    wire [7:0] status_set;
    wire [7:0] status_keep;
    wire [7:0] status_nxt;
    wire [7:0] mask_nxt;

    assign status_set  = {5'h00, clkpin_edge, hit[1], hit[0]};
    assign status_keep = status_rd ? io_mode_pkg::ZERO_RST : status_r;
    assign status_nxt  = status_keep | status_set;
    assign mask_nxt    = mask_we ? WDATA : mask_r;

    // count writes load the value; counters wrap silently at 255
    wire [1:0][7:0] count_nxt;

    assign count_nxt[0] = count_we[0] ? WDATA : (hit[0] ? count_r[0] + 8'h01 : count_r[0]);
    assign count_nxt[1] = count_we[1] ? WDATA : (hit[1] ? count_r[1] + 8'h01 : count_r[1]);

    // read selection
    wire [7:0] aux_in;
    wire [7:0] rd_mux;

    assign aux_in = {6'h00, clkpin_s, 1'b0};
    assign rd_mux =
        (ADDR == io_mode_pkg::ADDR_P0_SEL_LO) ? sel_lo_r[0] :
        (ADDR == io_mode_pkg::ADDR_P0_SEL_HI) ? sel_hi_r[0] :
        (ADDR == io_mode_pkg::ADDR_P1_SEL_LO) ? sel_lo_r[1] :
        (ADDR == io_mode_pkg::ADDR_P1_SEL_HI) ? sel_hi_r[1] :
        (ADDR == io_mode_pkg::ADDR_P0_DATA)   ? data_r[0]   :
        (ADDR == io_mode_pkg::ADDR_P1_DATA)   ? data_r[1]   :
        (ADDR == io_mode_pkg::ADDR_P0_EDGE)   ? edge_r[0]   :
        (ADDR == io_mode_pkg::ADDR_P1_EDGE)   ? edge_r[1]   :
        (ADDR == io_mode_pkg::ADDR_P0_INPUT)  ? pin_s[0]    :
        (ADDR == io_mode_pkg::ADDR_P1_INPUT)  ? pin_s[1]    :
        (ADDR == io_mode_pkg::ADDR_AUX_IN)    ? aux_in      :
        (ADDR == io_mode_pkg::ADDR_I2C_CTL)   ? ctl_r       :
        (ADDR == io_mode_pkg::ADDR_P0_COUNT)  ? count_r[0]  :
        (ADDR == io_mode_pkg::ADDR_P1_COUNT)  ? count_r[1]  :
        (ADDR == io_mode_pkg::ADDR_STATUS)    ? status_r    :
        (ADDR == io_mode_pkg::ADDR_MASK)      ? mask_r      :
        io_mode_pkg::ZERO_RST; // legacy setups and unmapped read zero

    // mode bits
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            sel_lo_r <= {2{io_mode_pkg::SEL_LO_RST}};
            sel_hi_r <= {2{io_mode_pkg::SEL_HI_RST}};
        end else begin
            if (sel_lo_we[0]) sel_lo_r[0] <= WDATA;
            if (sel_lo_we[1]) sel_lo_r[1] <= WDATA;
            if (sel_hi_we[0]) sel_hi_r[0] <= WDATA;
            if (sel_hi_we[1]) sel_hi_r[1] <= WDATA;
        end
    end

    // output levels, edge choice, i2c control
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            data_r <= {2{io_mode_pkg::DATA_RST}};
            edge_r <= {2{io_mode_pkg::EDGE_RST}};
            ctl_r  <= io_mode_pkg::ZERO_RST;
        end else begin
            if (data_we[0]) data_r[0] <= WDATA;
            if (data_we[1]) data_r[1] <= WDATA;
            if (edge_we[0]) edge_r[0] <= WDATA;
            if (edge_we[1]) edge_r[1] <= WDATA;
            if (ctl_we)     ctl_r     <= WDATA & 8'h03;
        end
    end

    // edge history and counters
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            pin_prev_r    <= {2{io_mode_pkg::ALL_ONES}};
            clkpin_prev_r <= 1'b1;
            count_r       <= {2{io_mode_pkg::ZERO_RST}};
        end else begin
            pin_prev_r    <= pin_s;
            clkpin_prev_r <= clkpin_s;
            count_r       <= count_nxt;
        end
    end

    // interrupt status, mask and line
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            status_r <= io_mode_pkg::ZERO_RST;
            mask_r   <= io_mode_pkg::ZERO_RST;
            irq_r    <= 1'b0;
        end else begin
            status_r <= status_nxt;
            mask_r   <= mask_nxt;
            irq_r    <= |(status_nxt & mask_nxt);
        end
    end

    // read data only in the cycle after the strobe
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            rdata_r <= io_mode_pkg::ZERO_RST;
        end else begin
            rdata_r <= RD ? rd_mux : io_mode_pkg::ZERO_RST;
        end
    end

    assign RDATA = rdata_r;
    assign IRQ   = irq_r;
endmodule
`default_nettype wire

/* tb/io_pin_mode_control_chk.sv */
// port-level assertions for the pin mode control block
`timescale 1ns/100ps
`default_nettype none
module io_pin_mode_control_chk #(
    parameter int W       = 8,
    parameter int SCL_PIN = 0,
    parameter int SDA_PIN = 1
) (
    input wire logic                            REF_CLK,
    input wire logic                            NRST,
    input wire logic [io_mode_pkg::AW-1:0]      ADDR,
    input wire logic [io_mode_pkg::DW-1:0]      WDATA,
    input wire logic                            WR,
    input wire logic                            RD,
    input wire logic [io_mode_pkg::DW-1:0]      RDATA,
    input wire logic                            CLK_PIN_IN,
    input wire io_mode_pkg::pin_drive_t [W-1:0] P0_PIN,
    input wire io_mode_pkg::pin_drive_t [W-1:0] P1_PIN,
    input wire logic                            IRQ
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    wire                          legacy = ADDR inside {[5'h08:5'h0B]};
    wire io_mode_pkg::pin_drive_t scl    = P0_PIN[SCL_PIN];
    wire io_mode_pkg::pin_drive_t sda    = P0_PIN[SDA_PIN];
    sequence s_ctl(logic [1:0] v);
        WR && ADDR == io_mode_pkg::ADDR_I2C_CTL && WDATA[1:0] == v;
    endsequence
    // a driven low must always sink, pull-up only on an undriven high
    property p_sane(io_mode_pkg::pin_drive_t d);
        (d.oe && !d.o |-> d.sink != io_mode_pkg::SINK_OFF) and (d.pu |-> d.o && !d.oe);
    endproperty
    a_boot_pins: assert property (disable iff (1'b0)
        !NRST |=> P0_PIN == {W{io_mode_pkg::DRIVE_RST}} && P1_PIN == {W{io_mode_pkg::DRIVE_RST}})
        else $error("pins not at boot drive after reset");
    a_boot_quiet: assert property (disable iff (1'b0)
        !NRST |=> !IRQ && RDATA == 8'h00) else $error("irq or read data set in reset");
    a_legacy_quiet: assert property (WR && legacy |=> ##1 $stable(P0_PIN) && $stable(P1_PIN))
        else $error("legacy setup changed a pin");
    a_legacy_read: assert property (RD && legacy |=> RDATA == 8'h00)
        else $error("legacy setup reads nonzero");
    a_pin_cause: assert property (
        $past(NRST) && ($changed(P0_PIN) || $changed(P1_PIN)) |-> $past(WR, 2))
        else $error("pin drive changed without a write");
    a_i2c_drive: assert property (s_ctl(2'b01) |=> ##1 scl.oe && sda.oe
        && (scl.o || scl.sink == io_mode_pkg::SINK_MED)) else $error("i2c pins not in mode 1");
    a_i2c_rx: assert property (s_ctl(2'b11) |=> ##1
        (scl.o ? scl.pu && !scl.oe : scl.sink == io_mode_pkg::SINK_LOW))
        else $error("i2c pins not in mode 2 on receive");
    a_aux_level: assert property (
        ($stable(CLK_PIN_IN) [*4]) ##0 (RD && ADDR == io_mode_pkg::ADDR_AUX_IN)
        |=> RDATA == {6'h00, $past(CLK_PIN_IN), 1'b0}) else $error("aux byte wrong");
    for (genvar k = 0; k < W; k++) begin : g_pin
        a_p0_drive: assert property (p_sane(P0_PIN[k]))
            else $error("port 0 drive fields inconsistent");
        a_p1_drive: assert property (p_sane(P1_PIN[k]))
            else $error("port 1 drive fields inconsistent");
    end
endmodule
`default_nettype wire

/* tb/pad_model.sv */
// board-side pad model: resolves each pad level from all drivers
`timescale 1ns/100ps
`default_nettype none
module pad_model #(
    parameter int W = 8
) (
    input  wire logic                            clk,
    input  wire io_mode_pkg::pin_drive_t [W-1:0] drive,
    input  wire logic [W-1:0]                    ext_en,
    input  wire logic [W-1:0]                    ext_lvl,
    output var  logic [W-1:0]                    pad
);
    logic [W-1:0] last_r = '0;
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (drive[i].oe)
                pad[i] = drive[i].o;
            else if (ext_en[i])
                pad[i] = ext_lvl[i];
            else if (drive[i].pu)
                pad[i] = 1'b1;
            else
                pad[i] = ~last_r[i];  // floating: never hold a level the logic could trust
        end
    end
    always_ff @(posedge clk)
        last_r <= pad;
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the pin mode control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int W = io_mode_pkg::PW;
    localparam logic [39:0] RST_PINS = 40'({W{io_mode_pkg::DRIVE_RST}});
    logic                            REF_CLK;
    logic                            NRST;
    logic [io_mode_pkg::AW-1:0]      ADDR;
    logic [io_mode_pkg::DW-1:0]      WDATA;
    logic                            WR;
    logic                            RD;
    logic [io_mode_pkg::DW-1:0]      RDATA;
    logic [W-1:0]                    P0_IN;
    logic [W-1:0]                    P1_IN;
    logic                            CLK_PIN_IN;
    io_mode_pkg::pin_drive_t [W-1:0] P0_PIN;
    io_mode_pkg::pin_drive_t [W-1:0] P1_PIN;
    logic                            IRQ;
    logic [1:0][W-1:0]               ext_en;
    logic [1:0][W-1:0]               ext_lvl;
    int                              failures;
    int                              cmp_count;
    logic [4:0]                      bad [5] = '{5'h08, 5'h09, 5'h0A, 5'h0B, 5'h1F};

    io_pin_mode_control dut (.REF_CLK, .NRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .P0_IN,
        .P1_IN, .CLK_PIN_IN, .P0_PIN, .P1_PIN, .IRQ);
    pad_model #(.W(W)) pad0 (.clk(REF_CLK), .drive(P0_PIN), .ext_en(ext_en[0]),
        .ext_lvl(ext_lvl[0]), .pad(P0_IN));
    pad_model #(.W(W)) pad1 (.clk(REF_CLK), .drive(P1_PIN), .ext_en(ext_en[1]),
        .ext_lvl(ext_lvl[1]), .pad(P1_IN));

    initial begin
        REF_CLK = 1'b0;
        forever #20 REF_CLK = ~REF_CLK;
    end

    task automatic chk(input logic [39:0] seen, input logic [39:0] want);
        cmp_count++;
        if (seen !== want) begin
            failures++;
            $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge REF_CLK);
        @(negedge REF_CLK);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge REF_CLK);
        WR    <= 1'b1;
        ADDR  <= a;
        WDATA <= d;
        @(posedge REF_CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] want);
        @(posedge REF_CLK);
        RD   <= 1'b1;
        ADDR <= a;
        @(posedge REF_CLK);
        RD <= 1'b0;
        @(negedge REF_CLK);
        chk(40'(RDATA), 40'(want));
    endtask
    // {mask, value}: the mask keeps only the fields that the mode pins down
    function automatic logic [9:0] exp_drive(input logic [1:0] m, input logic d);
        case ({m, d})
            3'h0, 3'h1: return {5'h0C, 5'h00};
            3'h2:       return {5'h1B, 5'h0A};
            3'h4:       return {5'h1B, 5'h09};
            3'h5:       return {5'h1C, 5'h14};
            3'h6:       return {5'h1B, 5'h0B};
            default:    return {5'h18, 5'h18};
        endcase
    endfunction
    task automatic pin(input int p, input int i, input logic [1:0] m, input logic d);
        logic [4:0] got;
        logic [9:0] e;
        got = p ? P1_PIN[i] : P0_PIN[i];
        e   = exp_drive(m, d);
        chk(40'(got & e[9:5]), 40'(e[4:0]));
    endtask
    task automatic reset_dut;
        @(posedge REF_CLK);
        NRST <= 1'b0;
        repeat (8) @(posedge REF_CLK);
        NRST <= 1'b1;
        @(negedge REF_CLK);
        chk(40'(P0_PIN), RST_PINS);
        chk(40'(P1_PIN), RST_PINS);
        chk(40'(IRQ), 40'h0);
        for (int a = 0; a < 4; a++)
            rd(5'(a), a[0] ? 8'hFF : 8'h00);
        $display("reset test done");
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge REF_CLK);
        failures++;
        summarize();
    end

    initial begin
        NRST       = 1'b0;
        ADDR       = '0;
        WDATA      = '0;
        WR         = 1'b0;
        RD         = 1'b0;
        // idles high like the synchroniser's reset level, so no false edge after reset
        CLK_PIN_IN = 1'b1;
        ext_en     = '0;
        ext_lvl    = '0;
        failures   = 0;
        cmp_count  = 0;
        reset_dut();
        for (int p = 0; p < 2; p++) begin
            for (int m = 0; m < 4; m++) begin
                wr(5'(2 * p), m[0] ? 8'h08 : 8'h00);
                wr(5'(2 * p + 1), m[1] ? 8'hFF : 8'hF7);
                for (int d = 0; d < 2; d++) begin
                    wr(5'(4 + p), d[0] ? 8'hFF : 8'h00);
                    cyc(2);
                    pin(p, 3, 2'(m), d[0]);
                    pin(p, 4, 2'h2, d[0]);
                end
                rd(5'(2 * p), m[0] ? 8'h08 : 8'h00);
            end
            wr(5'(2 * p), 8'h00);
            wr(5'(2 * p + 1), 8'hFF);
            wr(5'(4 + p), 8'hFF);
        end
        $display("mode table test done");
        foreach (bad[j]) begin
            wr(bad[j], 8'h00);
            rd(bad[j], 8'h00);
        end
        cyc(2);
        chk(40'(P0_PIN), RST_PINS);
        chk(40'(P1_PIN), RST_PINS);
        $display("legacy setup test done");
        for (int c = 1; c < 4; c += 2) begin
            for (int d = 0; d < 2; d++) begin
                wr(io_mode_pkg::ADDR_I2C_CTL, 8'(c));
                wr(io_mode_pkg::ADDR_P0_DATA, d[0] ? 8'hFF : 8'hFC);
                cyc(2);
                pin(0, 0, c == 3 ? 2'h2 : 2'h1, d[0]);
                pin(0, 1, c == 3 ? 2'h2 : 2'h1, d[0]);
                pin(0, 2, 2'h2, 1'b1);
            end
        end
        rd(io_mode_pkg::ADDR_P0_SEL_LO, 8'h00);
        rd(io_mode_pkg::ADDR_P0_SEL_HI, 8'hFF);
        rd(io_mode_pkg::ADDR_I2C_CTL, 8'h03);
        wr(io_mode_pkg::ADDR_I2C_CTL, 8'h00);
        $display("i2c mode test done");
        @(posedge REF_CLK);
        ext_en <= '1;
        wr(io_mode_pkg::ADDR_P0_SEL_HI, 8'h00);
        wr(io_mode_pkg::ADDR_P1_SEL_HI, 8'h00);
        wr(io_mode_pkg::ADDR_P1_EDGE, 8'h00);
        cyc(5);
        rd(io_mode_pkg::ADDR_STATUS, 8'h03);
        rd(io_mode_pkg::ADDR_STATUS, 8'h00);
        wr(io_mode_pkg::ADDR_P0_COUNT, 8'h00);
        wr(io_mode_pkg::ADDR_P1_COUNT, 8'h00);
        wr(io_mode_pkg::ADDR_MASK, 8'h03);
        for (int s = 0; s < 3; s++) begin
            @(posedge REF_CLK);
            ext_lvl <= s[0] ? 16'h0000 : 16'h0404;
            cyc(5);
            chk(40'(IRQ), s == 2 ? 40'h0 : 40'h1);
            rd(io_mode_pkg::ADDR_P0_COUNT, s == 2 ? 8'h02 : 8'h01);
            rd(io_mode_pkg::ADDR_P1_COUNT, s == 0 ? 8'h00 : 8'h01);
            rd(io_mode_pkg::ADDR_STATUS, s[0] ? 8'h02 : 8'h01);
            cyc(2);
            chk(40'(IRQ), 40'h0);
            if (s == 1)
                wr(io_mode_pkg::ADDR_MASK, 8'h00);
        end
        rd(io_mode_pkg::ADDR_P0_INPUT, 8'h04);
        rd(io_mode_pkg::ADDR_P1_INPUT, 8'h04);
        $display("event edge test done");
        for (int v = 0; v < 2; v++) begin
            @(posedge REF_CLK);
            CLK_PIN_IN <= v[0];
            cyc(4);
            rd(io_mode_pkg::ADDR_AUX_IN, v[0] ? 8'h02 : 8'h00);
            rd(io_mode_pkg::ADDR_STATUS, 8'h04);
        end
        $display("clock pin input test done");
        reset_dut();
        summarize();
    end
endmodule

bind io_pin_mode_control io_pin_mode_control_chk #(
    .W       (W),
    .SCL_PIN (SCL_PIN),
    .SDA_PIN (SDA_PIN)
) chk_i (.REF_CLK, .NRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .CLK_PIN_IN, .P0_PIN, .P1_PIN, .IRQ);
`default_nettype wire
